// ===== src/dsleep_gate_pkg.sv
// constants for the deep-sleep peripheral clock gate
// assumes a 32-bit axi4-lite register bus on one clock
package dsleep_gate_pkg;
  localparam int          NUM_UNITS = 9;
  localparam logic [11:0] DEEP_GATE_OFS  = 12'h124;
  localparam logic [11:0] RUN_GATE_OFS   = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
  localparam logic [11:0] CFG_OFS        = 12'h060;
  localparam logic [11:0] MODE_OFS       = 12'h200;
  localparam logic [11:0] IRQ_STAT_OFS   = 12'h204;
  localparam logic [11:0] IRQ_MASK_OFS   = 12'h208;
  localparam logic [31:0] GATE_MASK      = 32'h0707_1013;
  localparam logic [31:0] GATE_RESET     = 32'h0000_0000;
  localparam int          AUTO_GATE_BIT  = 27;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // register bit position of each unit gate, unit index 0..7; unit 8 uses UNIT_BIT8, not entry 8
  localparam int UNIT_BIT [NUM_UNITS] = '{0, 1, 4, 12, 16, 17, 18, 24, 25};
  localparam int UNIT_BIT8 = 26;
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP  = 2'b10
  } power_mode_e;
endpackage

// ===== src/unit_clock_gate.sv
// one glitch-free clock gate per unit plus fault check on its accesses
// assumes enable changes from the aclk domain; latch is transparent while clock low
`timescale 1ns/100ps
module unit_clock_gate (
  input  wire logic aclk,
  input  wire logic enable,
  input  wire logic access,
  output logic      gclk,
  output logic      fault
);
  logic en_latch;

  // latch on low phase keeps the gated clock free of runt pulses
  always_latch begin
    if (!aclk) begin
      en_latch = enable;
    end
  end

  assign gclk  = aclk & en_latch;
  assign fault = access & ~enable;
endmodule

// ===== src/deep_sleep_periph_clock_gate.sv
// deep-sleep peripheral clock gate with run and sleep companions
// assumes axi4-lite master on aclk, unit access strobes from the same clock
`timescale 1ns/100ps
module deep_sleep_periph_clock_gate #(
  parameter int ADDR_W = 12
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [1:0]          power_mode,
  input  wire logic [8:0]          unit_access,
  output logic [8:0]               unit_clk,
  output logic [8:0]               unit_clk_en,
  output logic [8:0]               unit_bus_fault,
  output logic                     irq
);
  logic [31:0] deep_gate_r;
  logic [31:0] run_gate_r;
  logic [31:0] sleep_gate_r;
  logic [31:0] cfg_r;
  logic [8:0]  irq_stat_r;
  logic [8:0]  irq_mask_r;
  logic [1:0]  mode_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_full_r;
  logic        w_full_r;
  logic [31:0] act_gate;
  logic [31:0] wmask;
  logic        wr_fire;
  logic        wr_hit;
  logic        rd_fire;
  logic [8:0]  fault_raw;
  logic [8:0]  unit_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= dsleep_gate_pkg::MODE_RUN;
    end else begin
      mode_r <= power_mode;
    end
  end

  // select the gating set for the current power state
  always_comb begin
    case (dsleep_gate_pkg::power_mode_e'(mode_r))
      dsleep_gate_pkg::MODE_DEEP:  act_gate = deep_gate_r;
      dsleep_gate_pkg::MODE_SLEEP:
        act_gate = cfg_r[dsleep_gate_pkg::AUTO_GATE_BIT] ? sleep_gate_r : run_gate_r;
      default:                     act_gate = run_gate_r;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < dsleep_gate_pkg::NUM_UNITS; g++) begin : gen_unit
      localparam int BITPOS = (g == 8) ? dsleep_gate_pkg::UNIT_BIT8 : dsleep_gate_pkg::UNIT_BIT[g];
      assign unit_en[g] = act_gate[BITPOS];
      unit_clock_gate u_gate (
        .aclk   (aclk),
        .enable (unit_en[g]),
        .access (unit_access[g]),
        .gclk   (unit_clk[g]),
        .fault  (fault_raw[g])
      );
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_clk_en    <= '0;
      unit_bus_fault <= '0;
    end else begin
      unit_clk_en    <= unit_en;
      unit_bus_fault <= fault_raw;
    end
  end

  // write channel capture: address and data accepted in any order
  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_r & ~s_axi_bvalid;
  assign wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{w_strb_r[i]}};
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (aw_addr_r == dsleep_gate_pkg::DEEP_GATE_OFS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_r == dsleep_gate_pkg::RUN_GATE_OFS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_r == dsleep_gate_pkg::SLEEP_GATE_OFS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_r == dsleep_gate_pkg::CFG_OFS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_r == dsleep_gate_pkg::IRQ_STAT_OFS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_r == dsleep_gate_pkg::IRQ_MASK_OFS) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // reserved bits never store a value, so they always read back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deep_gate_r  <= dsleep_gate_pkg::GATE_RESET;
      run_gate_r   <= dsleep_gate_pkg::GATE_RESET;
      sleep_gate_r <= dsleep_gate_pkg::GATE_RESET;
      cfg_r        <= '0;
    end else if (wr_fire) begin
      if (aw_addr_r == dsleep_gate_pkg::DEEP_GATE_OFS) begin
        deep_gate_r <= ((deep_gate_r & ~wmask) | (w_data_r & wmask)) & dsleep_gate_pkg::GATE_MASK;
      end else if (aw_addr_r == dsleep_gate_pkg::RUN_GATE_OFS) begin
        run_gate_r <= ((run_gate_r & ~wmask) | (w_data_r & wmask)) & dsleep_gate_pkg::GATE_MASK;
      end else if (aw_addr_r == dsleep_gate_pkg::SLEEP_GATE_OFS) begin
        sleep_gate_r <= ((sleep_gate_r & ~wmask) | (w_data_r & wmask)) & dsleep_gate_pkg::GATE_MASK;
      end else if (aw_addr_r == dsleep_gate_pkg::CFG_OFS) begin
        cfg_r[dsleep_gate_pkg::AUTO_GATE_BIT] <= wmask[dsleep_gate_pkg::AUTO_GATE_BIT]
          ? w_data_r[dsleep_gate_pkg::AUTO_GATE_BIT] : cfg_r[dsleep_gate_pkg::AUTO_GATE_BIT];
      end
    end
  end

  // fault events are sticky; a new fault wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      if (wr_fire && aw_addr_r == dsleep_gate_pkg::IRQ_STAT_OFS) begin
        irq_stat_r <= (irq_stat_r & ~(w_data_r[8:0] & wmask[8:0])) | fault_raw;
      end else begin
        irq_stat_r <= irq_stat_r | fault_raw;
      end
      if (wr_fire && aw_addr_r == dsleep_gate_pkg::IRQ_MASK_OFS) begin
        irq_mask_r <= (irq_mask_r & ~wmask[8:0]) | (w_data_r[8:0] & wmask[8:0]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dsleep_gate_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? dsleep_gate_pkg::RESP_OKAY : dsleep_gate_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one read in flight, answer the cycle after the address
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= dsleep_gate_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= dsleep_gate_pkg::RESP_OKAY;
      if (s_axi_araddr == dsleep_gate_pkg::DEEP_GATE_OFS) begin
        s_axi_rdata <= deep_gate_r & dsleep_gate_pkg::GATE_MASK;
      end else if (s_axi_araddr == dsleep_gate_pkg::RUN_GATE_OFS) begin
        s_axi_rdata <= run_gate_r;
      end else if (s_axi_araddr == dsleep_gate_pkg::SLEEP_GATE_OFS) begin
        s_axi_rdata <= sleep_gate_r;
      end else if (s_axi_araddr == dsleep_gate_pkg::CFG_OFS) begin
        s_axi_rdata <= cfg_r;
      end else if (s_axi_araddr == dsleep_gate_pkg::MODE_OFS) begin
        s_axi_rdata <= {21'h0_0000, unit_clk_en, mode_r};
      end else if (s_axi_araddr == dsleep_gate_pkg::IRQ_STAT_OFS) begin
        s_axi_rdata <= {23'h000000, irq_stat_r};
      end else if (s_axi_araddr == dsleep_gate_pkg::IRQ_MASK_OFS) begin
        s_axi_rdata <= {23'h000000, irq_mask_r};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= dsleep_gate_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== dv/dsleep_gate_props.sv
// assertions on the deep-sleep clock gate ports
// assumes one clock and a synchronous active-low reset; bound below
`timescale 1ns/100ps
module dsleep_gate_props #(
  parameter int ADDR_W = 12
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        power_mode,
  input wire logic [8:0]        unit_access,
  input wire logic [8:0]        unit_clk_en,
  input wire logic [8:0]        unit_bus_fault,
  input wire logic              irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_off; $rose(aresetn) |-> unit_clk_en == 9'h000 && !irq; endproperty
  a_rst_off: assert property (p_rst_off) else $error("gate on after reset");
  property p_fault; unit_bus_fault == ($past(unit_access) & ~unit_clk_en); endproperty
  a_fault: assert property (p_fault) else $error("bus fault mismatch");
  // a gate may only move within four cycles of a write or a mode change
  property p_quiet; (!s_axi_wvalid && !s_axi_bvalid && $stable(power_mode)) [*4] |=> $stable(unit_clk_en); endproperty
  a_quiet: assert property (p_quiet) else $error("gate moved without cause");
  property p_rsv; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h124 |=> (s_axi_rdata & 32'hF8F8_EFEC) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data dropped");
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while answer pending");
  property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
endmodule
bind deep_sleep_periph_clock_gate dsleep_gate_props #(.ADDR_W(ADDR_W)) u_dsleep_gate_props (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .power_mode, .unit_access, .unit_clk_en, .unit_bus_fault, .irq
);

// ===== dv/deep_sleep_periph_clock_gate_bench.sv
// bench for the deep-sleep clock gate over its register bus
// assumes package, design and checker compiled before it
`timescale 1ns/100ps
module deep_sleep_periph_clock_gate_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd_data;
  logic [1:0]  power_mode, resp;
  logic [8:0]  unit_access;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [8:0]  unit_clk_en, unit_bus_fault, unit_clk;
  int          errors, comparisons;
  // unit 8 is wired to comparator 2, bit 26; bit 25 only stores
  int          unit_pos [9] = '{0, 1, 4, 12, 16, 17, 18, 24, 26};
  deep_sleep_periph_clock_gate u_deep_sleep_periph_clock_gate (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .power_mode, .unit_access, .unit_clk, .unit_clk_en, .unit_bus_fault, .irq
  );
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ready is sampled at the falling edge, where nothing on the bus moves
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      b = s_axi_bvalid;
      if (b) resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask
  // rready rises only once the answer shows, so every read stalls one cycle
  task automatic rd(input logic [11:0] a);
    logic ta, tv, r;
    r = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      ta = s_axi_arready;
      tv = s_axi_rvalid;
      r = s_axi_rvalid && s_axi_rready;
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic mode(input logic [1:0] m, input logic [8:0] exp);
    power_mode <= m;
    repeat (3) @(posedge aclk);
    chk("unit_clk_en", unit_clk_en, exp);
  endtask
  task automatic t_fields();
    rd(12'h124);
    chk("deep reset", rd_data, 32'h0);
    wr(12'h124, 32'hFFFF_FFFF);
    rd(12'h124);
    chk("deep fields", rd_data, 32'h0707_1013);
    mode(2'h2, 9'h1FF);
    for (int i = 0; i < 9; i++) begin
      wr(12'h124, 32'h1 << unit_pos[i]);
      mode(2'h2, 9'h1 << i);
    end
    wr(12'h124, 32'h0400_0000);
    rd(12'h124);
    chk("cmp2 gate", rd_data, 32'h0400_0000);
    wr(12'h124, rd_data | 32'h0000_0010);
    rd(12'h124);
    chk("rmw keeps bits", rd_data, 32'h0400_0010);
  endtask
  task automatic t_fault();
    wr(12'h124, 32'h1);
    mode(2'h2, 9'h001);
    @(posedge aclk);
    #1;
    chk("unit_clk high", unit_clk, 9'h001);
    @(negedge aclk);
    #1;
    chk("unit_clk low", unit_clk, 9'h000);
    @(posedge aclk);
    unit_access <= 9'h1FF;
    @(posedge aclk);
    unit_access <= 9'h0;
    @(negedge aclk);
    chk("fault", unit_bus_fault, 9'h1FE);
    repeat (3) @(posedge aclk);
    chk("irq masked", irq, 1'b0);
    wr(12'h208, 32'h1FF);
    repeat (2) @(posedge aclk);
    chk("irq on", irq, 1'b1);
    wr(12'h204, 32'h1FF);
    repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 1'b0);
  endtask
  task automatic t_modes();
    wr(12'h100, 32'h2);
    wr(12'h110, 32'h10);
    mode(2'h0, 9'h002);
    mode(2'h1, 9'h002);
    wr(12'h060, 32'h0800_0000);
    mode(2'h1, 9'h004);
    mode(2'h2, 9'h001);
    mode(2'h3, 9'h002);
    rd(12'h300);
    chk("unmapped resp", resp, 2'h2);
    chk("unmapped data", rd_data, 32'h0);
    wr(12'h300, 32'h1);
    chk("unmapped bresp", resp, 2'h2);
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    test_done();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, power_mode, unit_access} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("en reset", unit_clk_en, 9'h0);
    t_fields();
    t_fault();
    t_modes();
    test_done();
  end
endmodule
